// *** rtl/ccp_pkg.sv ***
// Contract
// RULE1: digital brownout level field: 00=4.5V, 01=4.2V, 10=2.7V, 11=2.5V; default 11.
// RULE2: analog brownout level field uses the same encoding; default 11.
// RULE3: config bit 3 low enables analog brownout reset; disable needs analog supply over 2.0V.
// RULE4: config bit 2 low enables digital brownout reset; default set means disabled.
// RULE5: config bit 1 low puts port A on memory bus with port C strobes.
// RULE6: config bit 0 low puts port B on memory bus with port C strobes.
// RULE7: configuration bits change only by programming, never by ordinary register writes.
// RULE8: software reads config by writing address 7Eh then reading config data.
// RULE9: port A carries low address while latch strobe high, data while low.
// RULE10: in GPIO use, port A drive type comes from the two drive registers.
// RULE11: stack pointer increments before push or call, decrements after pop or return.
// RULE12: stack pointer resets to 07h.
// RULE13: each data pointer is a low and high byte forming a 16-bit pointer.
// RULE14: select bit 0 set makes pointer operations use the auxiliary pair.
// RULE15: external access while ports are GPIO leaves port values unchanged.
// RULE16: upper seven select bits read zero and ignore writes.
package ccp_pkg;
	localparam logic [7:0] CCP_ADDR_PORT_A = 8'h80;
	localparam logic [7:0] CCP_ADDR_SP = 8'h81;
	localparam logic [7:0] CCP_ADDR_PA_LOW = 8'h82;
	localparam logic [7:0] CCP_ADDR_PA_HIGH = 8'h83;
	localparam logic [7:0] CCP_ADDR_PB_LOW = 8'h84;
	localparam logic [7:0] CCP_ADDR_PB_HIGH = 8'h85;
	localparam logic [7:0] CCP_ADDR_SELECT = 8'h86;
	localparam logic [7:0] CCP_ADDR_CFG_ADDR = 8'h93;
	localparam logic [7:0] CCP_ADDR_CFG_DATA = 8'h94;
	localparam logic [7:0] CCP_ADDR_DRV_LOW = 8'hAC;
	localparam logic [7:0] CCP_ADDR_DRV_HIGH = 8'hAD;
	localparam logic [7:0] CCP_CFG_IDX_BROWNOUT = 8'h7E;
	localparam logic [7:0] CCP_RST_PORT_A = 8'hFF;
	localparam logic [7:0] CCP_RST_SP = 8'h07;
	localparam logic [7:0] CCP_RST_ZERO = 8'h00;
	localparam logic [7:0] CCP_RST_CONFIG = 8'hFF;
	localparam int CCP_BIT_DIG_LVL = 6;
	localparam int CCP_BIT_ANA_LVL = 4;
	localparam int CCP_BIT_ANA_DIS = 3;
	localparam int CCP_BIT_DIG_DIS = 2;
	localparam int CCP_BIT_PA_GPIO = 1;
	localparam int CCP_BIT_PBC_GPIO = 0;
	localparam int CCP_BIT_SELECT = 0;
	typedef enum logic [1:0] {
		CCP_LVL_4V5 = 2'b00,
		CCP_LVL_4V2 = 2'b01,
		CCP_LVL_2V7 = 2'b10,
		CCP_LVL_2V5 = 2'b11
	} ccp_level_t;
	typedef enum logic [1:0] {
		CCP_STK_NONE = 2'b00,
		CCP_STK_PUSH = 2'b01,
		CCP_STK_POP = 2'b10,
		CCP_STK_HOLD = 2'b11
	} ccp_stack_op_t;
endpackage

// *** rtl/ccp_core_regs.sv ***
`timescale 1ns/10ps
module ccp_core_regs import ccp_pkg::*; (
	// clock and reset
	input wire logic CLOCK_IN,
	input wire logic RST_B_IN,
	// special function register access
	input wire logic [7:0] SFR_ADDR_IN,
	input wire logic [7:0] SFR_WDATA_IN,
	input wire logic SFR_WR_IN,
	input wire logic SFR_RD_IN,
	output logic [7:0] SFR_RDATA_OUT,
	// programming mode load of the configuration byte
	input wire logic PROG_MODE_IN,
	input wire logic PROG_WR_IN,
	input wire logic [7:0] PROG_DATA_IN,
	// analog supply above 2.0V, from outside the clock domain
	input wire logic ANA_SUPPLY_OK_IN,
	// stack and pointer operations from the core
	input wire logic [1:0] STACK_OP_IN,
	input wire logic PTR_INC_IN,
	// external memory cycle
	input wire logic EXT_ACCESS_IN,
	input wire logic ADDR_LATCH_IN,
	input wire logic [15:0] EXT_ADDR_IN,
	input wire logic [7:0] EXT_WDATA_IN,
	input wire logic EXT_WRITE_IN,
	input wire logic EXT_READ_IN,
	// pins and derived controls
	output logic [7:0] PORT_A_OUT,
	output logic [7:0] PORT_A_OE_B_OUT,
	output logic [15:0] PORT_A_DRIVE_OUT,
	output logic [7:0] PORT_B_OUT,
	output logic PORT_B_BUS_OUT,
	output logic WR_STROBE_B_OUT,
	output logic RD_STROBE_B_OUT,
	output logic [15:0] ACTIVE_POINTER_OUT,
	output logic [7:0] STACK_POINTER_OUT,
	output logic [1:0] DIG_BROWNOUT_LEVEL_OUT,
	output logic [1:0] ANA_BROWNOUT_LEVEL_OUT,
	output logic DIG_BROWNOUT_EN_OUT,
	output logic ANA_BROWNOUT_EN_OUT
);
	logic [7:0] config_q;
	logic [7:0] port_a_latch_q;
	logic [7:0] stack_pointer_q;
	logic [7:0] ptr_low_q [2];
	logic [7:0] ptr_high_q [2];
	logic pointer_select_q;
	logic [7:0] config_address_q;
	logic [7:0] config_data_q;
	logic [7:0] drive_low_q;
	logic [7:0] drive_high_q;
	logic [2:0] ana_sync_q;
	logic ana_ok_q;
	logic [7:0] rdata_d;
	logic [15:0] cur_ptr;
	logic [15:0] next_ptr;
	logic pa_bus;
	logic pb_bus;

	// the byte reloads FFh on reset; otherwise it is only loaded in programming mode
	always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			config_q <= CCP_RST_CONFIG;
		end else if (PROG_MODE_IN && PROG_WR_IN) begin // [RULE7]
			config_q <= PROG_DATA_IN;
		end
	end

	assign pa_bus = !config_q[CCP_BIT_PA_GPIO]; // [RULE5]
	assign pb_bus = !config_q[CCP_BIT_PBC_GPIO]; // [RULE6]

	// three-stage sampling; the first stage feeds only the second
	always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			ana_sync_q <= 3'h0;
			ana_ok_q <= 1'b0;
		end else begin
			ana_sync_q <= {ana_sync_q[1:0], ANA_SUPPLY_OK_IN};
			if (ana_sync_q[1] == ana_sync_q[2]) begin
				ana_ok_q <= ana_sync_q[2];
			end
		end
	end

	always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			DIG_BROWNOUT_LEVEL_OUT <= CCP_LVL_2V5;
			ANA_BROWNOUT_LEVEL_OUT <= CCP_LVL_2V5;
			DIG_BROWNOUT_EN_OUT <= 1'b0;
			ANA_BROWNOUT_EN_OUT <= 1'b1;
		end else begin
			DIG_BROWNOUT_LEVEL_OUT <= config_q[CCP_BIT_DIG_LVL +: 2]; // [RULE1]
			ANA_BROWNOUT_LEVEL_OUT <= config_q[CCP_BIT_ANA_LVL +: 2]; // [RULE2]
			DIG_BROWNOUT_EN_OUT <= !config_q[CCP_BIT_DIG_DIS]; // [RULE4]
			// a weak analog supply keeps the reset armed whatever the bit says
			ANA_BROWNOUT_EN_OUT <= !config_q[CCP_BIT_ANA_DIS] || !ana_ok_q; // [RULE3]
		end
	end

	always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			port_a_latch_q <= CCP_RST_PORT_A;
		end else if (SFR_WR_IN && SFR_ADDR_IN == CCP_ADDR_PORT_A) begin
			port_a_latch_q <= SFR_WDATA_IN;
		end
	end

	// software write wins over a same-cycle push or pop
	always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			stack_pointer_q <= CCP_RST_SP; // [RULE12]
		end else if (SFR_WR_IN && SFR_ADDR_IN == CCP_ADDR_SP) begin
			stack_pointer_q <= SFR_WDATA_IN;
		end else begin
			case (ccp_stack_op_t'(STACK_OP_IN))
				CCP_STK_PUSH: begin
					stack_pointer_q <= stack_pointer_q + 8'h01; // [RULE11]
				end
				CCP_STK_POP: begin
					stack_pointer_q <= stack_pointer_q - 8'h01; // [RULE11]
				end
				default: begin
					stack_pointer_q <= stack_pointer_q;
				end
			endcase
		end
	end

	assign cur_ptr = {ptr_high_q[pointer_select_q], ptr_low_q[pointer_select_q]}; // [RULE13]
	assign next_ptr = cur_ptr + 16'h0001;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_ptr
			localparam logic [7:0] ADDR_LOW = (g == 0) ? CCP_ADDR_PA_LOW : CCP_ADDR_PB_LOW;
			localparam logic [7:0] ADDR_HIGH = (g == 0) ? CCP_ADDR_PA_HIGH : CCP_ADDR_PB_HIGH;
			always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
				if (!RST_B_IN) begin
					ptr_low_q[g] <= CCP_RST_ZERO;
					ptr_high_q[g] <= CCP_RST_ZERO;
				end else if (SFR_WR_IN && SFR_ADDR_IN == ADDR_LOW) begin
					ptr_low_q[g] <= SFR_WDATA_IN;
				end else if (SFR_WR_IN && SFR_ADDR_IN == ADDR_HIGH) begin
					ptr_high_q[g] <= SFR_WDATA_IN;
				end else if (PTR_INC_IN && pointer_select_q == 1'(g)) begin // [RULE14]
					ptr_low_q[g] <= next_ptr[7:0];
					ptr_high_q[g] <= next_ptr[15:8];
				end
			end
		end
	endgenerate

	always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			pointer_select_q <= 1'b0;
		end else if (SFR_WR_IN && SFR_ADDR_IN == CCP_ADDR_SELECT) begin
			pointer_select_q <= SFR_WDATA_IN[CCP_BIT_SELECT]; // [RULE16]
		end
	end

	// config data is a read-only window; writes to it are ignored and the shadow refreshes every cycle
	always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			config_address_q <= CCP_RST_ZERO;
			config_data_q <= CCP_RST_ZERO;
		end else begin
			if (SFR_WR_IN && SFR_ADDR_IN == CCP_ADDR_CFG_ADDR) begin
				config_address_q <= SFR_WDATA_IN;
			end
			if (config_address_q == CCP_CFG_IDX_BROWNOUT) begin // [RULE8]
				config_data_q <= config_q;
			end else begin
				config_data_q <= CCP_RST_ZERO;
			end
		end
	end

	always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			drive_low_q <= CCP_RST_ZERO;
			drive_high_q <= CCP_RST_ZERO;
		end else if (SFR_WR_IN && SFR_ADDR_IN == CCP_ADDR_DRV_LOW) begin
			drive_low_q <= SFR_WDATA_IN;
		end else if (SFR_WR_IN && SFR_ADDR_IN == CCP_ADDR_DRV_HIGH) begin
			drive_high_q <= SFR_WDATA_IN;
		end
	end

	always_comb begin
		case (SFR_ADDR_IN)
			CCP_ADDR_PORT_A: rdata_d = port_a_latch_q;
			CCP_ADDR_SP: rdata_d = stack_pointer_q;
			CCP_ADDR_PA_LOW: rdata_d = ptr_low_q[0];
			CCP_ADDR_PA_HIGH: rdata_d = ptr_high_q[0];
			CCP_ADDR_PB_LOW: rdata_d = ptr_low_q[1];
			CCP_ADDR_PB_HIGH: rdata_d = ptr_high_q[1];
			CCP_ADDR_SELECT: rdata_d = {7'h00, pointer_select_q}; // [RULE16]
			CCP_ADDR_CFG_ADDR: rdata_d = config_address_q;
			CCP_ADDR_CFG_DATA: rdata_d = config_data_q; // [RULE8]
			CCP_ADDR_DRV_LOW: rdata_d = drive_low_q;
			CCP_ADDR_DRV_HIGH: rdata_d = drive_high_q;
			default: rdata_d = CCP_RST_ZERO;
		endcase
	end

	// read data is registered: it appears one cycle after the strobe
	always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			SFR_RDATA_OUT <= CCP_RST_ZERO;
		end else if (SFR_RD_IN) begin
			SFR_RDATA_OUT <= rdata_d;
		end
	end

	always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			PORT_A_OUT <= CCP_RST_PORT_A;
			PORT_A_OE_B_OUT <= 8'hFF;
			PORT_A_DRIVE_OUT <= 16'h0000;
			PORT_B_OUT <= CCP_RST_PORT_A;
			PORT_B_BUS_OUT <= 1'b0;
			WR_STROBE_B_OUT <= 1'b1;
			RD_STROBE_B_OUT <= 1'b1;
			ACTIVE_POINTER_OUT <= 16'h0000;
			STACK_POINTER_OUT <= CCP_RST_SP;
		end else begin
			ACTIVE_POINTER_OUT <= cur_ptr; // [RULE14]
			STACK_POINTER_OUT <= stack_pointer_q;
			PORT_A_DRIVE_OUT <= {drive_high_q, drive_low_q}; // [RULE10]
			PORT_B_BUS_OUT <= pb_bus && EXT_ACCESS_IN;
			// gpio ports ignore bus cycles: port A pins keep their latch value, port B pins stay at FFh
			if (pa_bus && EXT_ACCESS_IN) begin // [RULE15]
				if (ADDR_LATCH_IN) begin
					PORT_A_OUT <= EXT_ADDR_IN[7:0]; // [RULE9]
					PORT_A_OE_B_OUT <= 8'h00;
				end else begin
					PORT_A_OUT <= EXT_WDATA_IN; // [RULE9]
					PORT_A_OE_B_OUT <= EXT_WRITE_IN ? 8'h00 : 8'hFF;
				end
			end else begin
				PORT_A_OUT <= port_a_latch_q;
				PORT_A_OE_B_OUT <= 8'h00;
			end
			if (pb_bus && EXT_ACCESS_IN) begin // [RULE6]
				PORT_B_OUT <= EXT_ADDR_IN[15:8];
			end else begin
				PORT_B_OUT <= CCP_RST_PORT_A; // [RULE15]
			end
			if ((pa_bus || pb_bus) && EXT_ACCESS_IN && !ADDR_LATCH_IN) begin // [RULE5]
				WR_STROBE_B_OUT <= !EXT_WRITE_IN;
				RD_STROBE_B_OUT <= !EXT_READ_IN;
			end else begin
				WR_STROBE_B_OUT <= 1'b1;
				RD_STROBE_B_OUT <= 1'b1;
			end
		end
	end
endmodule // ccp_core_regs

// *** dv/ccp_core_regs_properties.sv ***
`timescale 1ns/10ps
module ccp_core_regs_props import ccp_pkg::*; (
	// clock, reset and register access
	input wire logic CLOCK_IN, RST_B_IN, SFR_RD_IN,
	input wire logic [7:0] SFR_ADDR_IN, SFR_RDATA_OUT,
	// programming and core operations
	input wire logic PROG_MODE_IN, PROG_WR_IN,
	input wire logic [7:0] PROG_DATA_IN,
	input wire logic [1:0] STACK_OP_IN,
	input wire logic SFR_WR_IN, EXT_ACCESS_IN, ADDR_LATCH_IN,
	// observed outputs
	input wire logic PORT_B_BUS_OUT, WR_STROBE_B_OUT, DIG_BROWNOUT_EN_OUT,
	input wire logic [7:0] PORT_B_OUT, STACK_POINTER_OUT,
	input wire logic [1:0] DIG_BROWNOUT_LEVEL_OUT, ANA_BROWNOUT_LEVEL_OUT
);
	default clocking @(posedge CLOCK_IN); endclocking
	default disable iff (!RST_B_IN);
	wire prog_load = PROG_MODE_IN && PROG_WR_IN;
	sp_reset_a: assert property ($rose(RST_B_IN) |-> STACK_POINTER_OUT == 8'h07)
		else $error("stack pointer not 07 after reset");
	// state and output register stack up, so effects show two edges after the cause
	sp_push_a: assert property (STACK_OP_IN == 2'b01 && !SFR_WR_IN |-> ##2
		STACK_POINTER_OUT == $past(STACK_POINTER_OUT) + 8'h01) else $error("push missed");
	sp_pop_a: assert property (STACK_OP_IN == 2'b10 && !SFR_WR_IN |-> ##2
		STACK_POINTER_OUT == $past(STACK_POINTER_OUT) - 8'h01) else $error("pop missed");
	cfg_hold_a: assert property (!prog_load |-> ##2 $stable(DIG_BROWNOUT_LEVEL_OUT)
		&& $stable(ANA_BROWNOUT_LEVEL_OUT)) else $error("config moved without programming");
	lvl_load_a: assert property (prog_load |-> ##2
		DIG_BROWNOUT_LEVEL_OUT == $past(PROG_DATA_IN[7:6], 2)
		&& ANA_BROWNOUT_LEVEL_OUT == $past(PROG_DATA_IN[5:4], 2)) else $error("level mismatch");
	den_load_a: assert property (prog_load |-> ##2
		DIG_BROWNOUT_EN_OUT == !$past(PROG_DATA_IN[2], 2)) else $error("digital enable mismatch");
	portb_idle_a: assert property (!EXT_ACCESS_IN |=> !PORT_B_BUS_OUT
		&& PORT_B_OUT == 8'hFF) else $error("port b moved outside a bus cycle");
	wr_strobe_a: assert property (!WR_STROBE_B_OUT |-> $past(EXT_ACCESS_IN && !ADDR_LATCH_IN))
		else $error("write strobe outside data phase");
	sel_zero_a: assert property (SFR_RD_IN && SFR_ADDR_IN == CCP_ADDR_SELECT |=>
		SFR_RDATA_OUT[7:1] == 7'h00) else $error("select upper bits not zero");
	cover property (STACK_OP_IN == 2'b01);
	cover property (prog_load);
	cover property (!WR_STROBE_B_OUT);
endmodule // ccp_core_regs_props
bind ccp_core_regs ccp_core_regs_props props_u (.*);

// *** dv/ccp_ext_mem_model.sv ***
`timescale 1ns/10ps
// far-side memory; takes ale_in one cycle late to line up with the registered pins, and writes on the pin strobe as it stands
module ccp_ext_mem_model (
	input wire logic clk_in,
	input wire logic ale_in,
	input wire logic [7:0] port_a_in,
	input wire logic [7:0] port_b_in,
	input wire logic wr_b_in,
	output logic [15:0] addr_out,
	output logic [7:0] data_out
);
	logic ale_q;
	logic [7:0] mem_q [0:255];
	always_ff @(posedge clk_in) begin
		ale_q <= ale_in;
		if (ale_q) addr_out <= {port_b_in, port_a_in};
		if (!wr_b_in) mem_q[addr_out[7:0]] <= port_a_in;
	end
	assign data_out = mem_q[addr_out[7:0]];
endmodule // ccp_ext_mem_model

// *** dv/tb_top.sv ***
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_top import ccp_pkg::*;;
	logic CLOCK_IN, RST_B_IN, SFR_WR_IN, SFR_RD_IN, PROG_MODE_IN, PROG_WR_IN, ANA_SUPPLY_OK_IN;
	logic PTR_INC_IN, EXT_ACCESS_IN, ADDR_LATCH_IN, EXT_WRITE_IN, EXT_READ_IN;
	logic [7:0] SFR_ADDR_IN, SFR_WDATA_IN, PROG_DATA_IN, EXT_WDATA_IN, SFR_RDATA_OUT;
	logic [7:0] PORT_A_OUT, PORT_A_OE_B_OUT, PORT_B_OUT, STACK_POINTER_OUT, cb, e, mem_data;
	logic [15:0] EXT_ADDR_IN, PORT_A_DRIVE_OUT, ACTIVE_POINTER_OUT, mem_addr;
	logic [1:0] STACK_OP_IN, DIG_BROWNOUT_LEVEL_OUT, ANA_BROWNOUT_LEVEL_OUT, op;
	logic PORT_B_BUS_OUT, WR_STROBE_B_OUT, RD_STROBE_B_OUT, DIG_BROWNOUT_EN_OUT, ANA_BROWNOUT_EN_OUT;
	logic [7:0] ra [11] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h93, 8'h94,
		8'hAC, 8'hAD};
	logic [31:0] v;
	integer seed = 32'h06d1;
	int err_count = 0;
	int n_compared = 0;
	ccp_core_regs dut_u (.*);
	ccp_ext_mem_model mem_u (.clk_in(CLOCK_IN), .ale_in(ADDR_LATCH_IN), .port_a_in(PORT_A_OUT),
		.port_b_in(PORT_B_OUT), .wr_b_in(WR_STROBE_B_OUT), .addr_out(mem_addr), .data_out(mem_data));
	function automatic logic [7:0] rst_val(input logic [7:0] a);
		return (a == 8'h80) ? 8'hFF : (a == 8'h81) ? 8'h07 : 8'h00;
	endfunction
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge CLOCK_IN);
		{SFR_ADDR_IN, SFR_WDATA_IN, SFR_WR_IN} <= {a, d, 1'b1};
		@(posedge CLOCK_IN);
		SFR_WR_IN <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		@(posedge CLOCK_IN);
		{SFR_ADDR_IN, SFR_RD_IN} <= {a, 1'b1};
		@(posedge CLOCK_IN);
		SFR_RD_IN <= 1'b0;
		#1 `CHK("rdata", x, SFR_RDATA_OUT)
	endtask
	task automatic prog(input logic [7:0] d);
		@(posedge CLOCK_IN);
		{PROG_MODE_IN, PROG_WR_IN, PROG_DATA_IN} <= {2'b11, d};
		@(posedge CLOCK_IN);
		{PROG_MODE_IN, PROG_WR_IN} <= 2'b00;
		@(posedge CLOCK_IN);
		#1;
	endtask
	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		CLOCK_IN = 1'b0;
		forever #20 CLOCK_IN = ~CLOCK_IN;
	end
	initial begin
		#(40 * 20000);
		err_count++;
		give_verdict();
	end
	initial begin
		{RST_B_IN, SFR_WR_IN, SFR_RD_IN, PROG_MODE_IN, PROG_WR_IN, PTR_INC_IN, EXT_ACCESS_IN} = '0;
		{ADDR_LATCH_IN, EXT_WRITE_IN, EXT_READ_IN, SFR_ADDR_IN, SFR_WDATA_IN, PROG_DATA_IN} = '0;
		{EXT_WDATA_IN, EXT_ADDR_IN, STACK_OP_IN} = '0;
		ANA_SUPPLY_OK_IN = 1'b1;
		repeat (6) @(posedge CLOCK_IN);
		RST_B_IN <= 1'b1;
		foreach (ra[i]) rd(ra[i], rst_val(ra[i]));
		wr(8'h86, 8'hFF);
		rd(8'h86, 8'h01);
		wr(8'h93, 8'h7F);
		rd(8'h94, 8'h00);
		$display("test reset and select done");
		for (int i = 0; i < 4; i++) begin
			v = $random(seed);
			// carry from the low byte into the high byte on the first pass
			if (i == 0) v[15:0] = 16'h00FF;
			wr(8'h82, v[7:0]);
			wr(8'h83, v[15:8]);
			wr(8'h84, v[23:16]);
			wr(8'h85, v[31:24]);
			wr(8'h86, {7'h7F, i[0]});
			@(posedge CLOCK_IN);
			#1 `CHK("pointer", i[0] ? v[31:16] : v[15:0], ACTIVE_POINTER_OUT)
			@(posedge CLOCK_IN);
			PTR_INC_IN <= 1'b1;
			@(posedge CLOCK_IN);
			PTR_INC_IN <= 1'b0;
			@(posedge CLOCK_IN);
			#1 `CHK("pointer inc", (i[0] ? v[31:16] : v[15:0]) + 16'h0001, ACTIVE_POINTER_OUT)
			rd(i[0] ? 8'h82 : 8'h84, i[0] ? v[7:0] : v[23:16]);
		end
		$display("test pointers done");
		e = 8'h07;
		for (int k = 0; k < 24; k++) begin
			@(posedge CLOCK_IN);
			op = 2'($random(seed));
			STACK_OP_IN <= op;
			e = e + (op == 2'b01) - (op == 2'b10);
		end
		@(posedge CLOCK_IN);
		STACK_OP_IN <= 2'b00;
		@(posedge CLOCK_IN);
		#1 `CHK("stack", e, STACK_POINTER_OUT)
		$display("test stack done");
		for (int k = 0; k < 4; k++) begin
			v = $random(seed);
			// the last pass sets the analog disable bit so the low-supply check can trip
			cb = {2'(k), 2'(3 - k), (k == 3) | v[3], v[2:0]};
			prog(cb);
			`CHK("dig level", cb[7:6], DIG_BROWNOUT_LEVEL_OUT)
			`CHK("ana level", cb[5:4], ANA_BROWNOUT_LEVEL_OUT)
			`CHK("ana enable", !cb[3], ANA_BROWNOUT_EN_OUT)
			`CHK("dig enable", !cb[2], DIG_BROWNOUT_EN_OUT)
			wr(8'h94, ~cb);
			wr(8'h93, 8'h7E);
			rd(8'h94, cb);
		end
		@(posedge CLOCK_IN);
		ANA_SUPPLY_OK_IN <= 1'b0;
		repeat (5) @(posedge CLOCK_IN);
		#1 `CHK("low supply enable", 1'b1, ANA_BROWNOUT_EN_OUT)
		$display("test config done");
		prog(8'hFC);
		wr(8'hAC, v[7:0]);
		wr(8'hAD, v[15:8]);
		@(posedge CLOCK_IN);
		#1 `CHK("drive", v[15:0], PORT_A_DRIVE_OUT)
		@(posedge CLOCK_IN);
		{EXT_ACCESS_IN, ADDR_LATCH_IN, EXT_ADDR_IN, EXT_WDATA_IN} <= {2'b11, v[15:0], v[23:16]};
		@(posedge CLOCK_IN);
		{ADDR_LATCH_IN, EXT_WRITE_IN} <= 2'b01;
		#1 `CHK("addr low", v[7:0], PORT_A_OUT)
		`CHK("addr high", v[15:8], PORT_B_OUT)
		`CHK("addr drive", 8'h00, PORT_A_OE_B_OUT)
		@(posedge CLOCK_IN);
		#1 `CHK("data", v[23:16], PORT_A_OUT)
		`CHK("wr strobe", 1'b0, WR_STROBE_B_OUT)
		`CHK("data drive", 8'h00, PORT_A_OE_B_OUT)
		@(posedge CLOCK_IN);
		{EXT_ACCESS_IN, EXT_WRITE_IN} <= 2'b00;
		repeat (2) @(posedge CLOCK_IN);
		#1 `CHK("far memory", v[23:16], mem_data)
		@(posedge CLOCK_IN);
		{EXT_ACCESS_IN, EXT_READ_IN} <= 2'b11;
		@(posedge CLOCK_IN);
		#1 `CHK("rd strobe", 1'b0, RD_STROBE_B_OUT)
		`CHK("read release", 8'hFF, PORT_A_OE_B_OUT)
		@(posedge CLOCK_IN);
		{EXT_ACCESS_IN, EXT_READ_IN} <= 2'b00;
		prog(8'hFF);
		wr(8'h80, v[31:24]);
		@(posedge CLOCK_IN);
		{EXT_ACCESS_IN, EXT_WRITE_IN} <= 2'b11;
		repeat (2) @(posedge CLOCK_IN);
		#1 `CHK("gpio a", v[31:24], PORT_A_OUT)
		`CHK("gpio strobe", 1'b1, WR_STROBE_B_OUT)
		`CHK("gpio b", 8'hFF, PORT_B_OUT)
		$display("test external bus done");
		wr(8'h81, 8'h5A);
		@(posedge CLOCK_IN);
		{EXT_ACCESS_IN, EXT_WRITE_IN, RST_B_IN} <= 3'b000;
		repeat (2) @(posedge CLOCK_IN);
		RST_B_IN <= 1'b1;
		rd(8'h81, 8'h07);
		$display("test mid-run reset done");
		give_verdict();
	end
endmodule // tb_top
